// ===== rtl/rbv_reset_ctrl.sv
// Purpose: Cold and warm reset sequencing, boot vector selection, bus clock.
// Assumes: All pins synchronous to clk except the two reset inputs.
// Notes:   Overview of operation follows.
//
// Overview of operation
// [R1] Cold reset input low reinitialises processor state.
// [R2] Cold reset loads vector and locks PLL.
// [R3] Select high takes the externally supplied vector.
// [R4] Select low reads vector from on-chip storage.
// [R5] Outside low on warm line starts warm reset.
// [R6] Drive warm line low during warm reset.
// [R7] Processor runs at multiple; master clock times bus.
// [R8] Drive bus clock output as bus reference.
// [R9] Synchronise reset input release to master clock.
`timescale 1ns/1ns

module rbv_reset_ctrl
  import rbv_pkg::*;
#(
  parameter int unsigned WARM_CYC = WARM_HOLD_CYC  // Warm line hold in cycles.
) (
  // Clock and device reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Reset pins
  input  wire logic              coldResetN,
  input  wire logic              warmLineIn,
  output logic                   warmLineOut,
  output logic                   warmLineOe,
  input  wire logic              warmReq,
  // Boot vector sources
  input  wire logic              bootSelect,
  input  wire logic [BOOT_W-1:0] extVector,
  output logic                   nvReq,
  input  wire logic              nvValid,
  input  wire logic [BOOT_W-1:0] nvData,
  output rbv_boot_s              bootCfg,
  // PLL and clocks
  output logic                   pllResetN,
  input  wire logic              pllLocked,
  output logic [MULT_W-1:0]      pllMult,
  output logic                   busClock,
  // Core reset
  output logic                   coreResetN
);

  // ****************************************************************
  // Reset and input synchronisers
  // ****************************************************************
  logic rstSync1, rstSync2;    // Device reset release pipeline.
  logic coldSync1, coldSync2;  // Cold reset input synchroniser.
  logic warmSync1, warmSync2;  // Warm line input synchroniser.

  // Release of rst_n passes through two flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  // Both reset inputs are retimed before the sequencer sees them.
  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      coldSync1 <= 1'b0;
      coldSync2 <= 1'b0;
      warmSync1 <= 1'b1;
      warmSync2 <= 1'b1;
    end else begin
      coldSync1 <= coldResetN;  // R9
      coldSync2 <= coldSync1;   // R9
      warmSync1 <= warmLineIn;  // R9
      warmSync2 <= warmSync1;   // R9
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  rbv_state_e            state_reg, state_next;     // Sequencer state.
  logic [WARM_CNT_W-1:0] warmCnt_reg, warmCnt_next; // Warm hold counter.
  rbv_boot_s             boot_reg, boot_next;       // Loaded boot vector.
  logic                  nvReq_reg, nvReq_next;     // Storage read request.
  logic                  core_reg, core_next;       // Core reset release.
  logic                  pll_reg, pll_next;         // PLL reset release.
  logic                  oe_reg, oe_next;           // Warm line drive enable.
  logic [MULT_W-1:0]     mult_reg;                  // Multiplier select.

  // Next state and outputs of the reset sequence.
  always_comb begin
    state_next   = state_reg;
    warmCnt_next = warmCnt_reg;
    boot_next    = boot_reg;
    nvReq_next   = 1'b0;
    case (state_reg)
      ST_COLD: begin
        // Stay here until the synchronised cold input is released.
        boot_next.valid = 1'b0;
        if (coldSync2) begin
          state_next = ST_BOOT;  // R2
        end
      end
      ST_BOOT: begin
        if (bootSelect) begin
          boot_next  = '{vec: extVector, fromExt: 1'b1, valid: 1'b1};  // R3
          state_next = ST_PLL;   // R2
        end else if (nvValid) begin
          boot_next  = '{vec: nvData, fromExt: 1'b0, valid: 1'b1};     // R4
          state_next = ST_PLL;
        end else begin
          nvReq_next = 1'b1;     // R4
        end
      end
      ST_PLL: begin
        // The PLL reset is released; wait for it to lock.
        if (pllLocked) begin
          state_next = ST_RUN;   // R2
        end
      end
      ST_RUN: begin
        // Outside assertion or internal request starts a warm reset.
        if (!warmSync2 || warmReq) begin
          state_next   = ST_WARM;  // R5
          warmCnt_next = '0;
        end
      end
      ST_WARM: begin
        // Hold the line for the least warm reset time.
        if (warmCnt_reg == WARM_CNT_W'(WARM_CYC - 1)) begin
          state_next = ST_WREL;
        end else begin
          warmCnt_next = warmCnt_reg + 1'b1;
        end
      end
      ST_WREL: begin
        // Outside party may still hold the line; wait for it.
        if (warmSync2) begin
          state_next = ST_RUN;     // R5
        end
      end
      default: begin
        state_next = ST_COLD;
      end
    endcase
    // Cold reset overrides every other state.
    if (!coldSync2) begin
      state_next      = ST_COLD;   // R1
      // The loaded vector is void from the first cycle of a cold reset.
      boot_next.valid = 1'b0;      // R1
    end
    core_next = (state_next == ST_RUN);   // R1
    pll_next  = (state_next != ST_COLD);  // R2
    oe_next   = (state_next == ST_WARM);  // R6
    if (state_next != ST_BOOT) begin
      nvReq_next = 1'b0;
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      state_reg   <= ST_COLD;
      warmCnt_reg <= '0;
      boot_reg    <= '0;
      nvReq_reg   <= 1'b0;
      core_reg    <= 1'b0;
      pll_reg     <= 1'b0;
      oe_reg      <= 1'b0;
      mult_reg    <= '0;
    end else begin
      state_reg   <= state_next;
      warmCnt_reg <= warmCnt_next;
      boot_reg    <= boot_next;
      nvReq_reg   <= nvReq_next;
      core_reg    <= core_next;
      pll_reg     <= pll_next;
      oe_reg      <= oe_next;
      mult_reg    <= MULT_W'(CPU_MULT);  // R7
    end
  end

  // ****************************************************************
  // Bus clock divider
  // ****************************************************************
  logic [BUS_CNT_W-1:0] busCnt_reg, busCnt_next;  // Half period counter.
  logic                 busClk_reg, busClk_next;  // Bus clock level.

  // The bus clock toggles every BUS_HALF master cycles.
  always_comb begin
    busClk_next = busClk_reg;
    busCnt_next = busCnt_reg + 1'b1;
    if (busCnt_reg == BUS_CNT_W'(BUS_HALF - 1)) begin
      busCnt_next = '0;
      busClk_next = ~busClk_reg;  // R7 R8
    end
  end

  // Bus clock registers.
  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      busCnt_reg <= '0;
      busClk_reg <= 1'b0;
    end else begin
      busCnt_reg <= busCnt_next;
      busClk_reg <= busClk_next;
    end
  end

  // Outputs come straight from flip-flops; the line is only ever pulled low.
  assign warmLineOut = 1'b0 & oe_reg;
  assign warmLineOe  = oe_reg;
  assign nvReq       = nvReq_reg;
  assign bootCfg     = boot_reg;
  assign pllResetN   = pll_reg;
  assign pllMult     = mult_reg;
  assign busClock    = busClk_reg;
  assign coreResetN  = core_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync2);

  a_cold_entry: assert property (!coldSync2 |=> state_reg == ST_COLD && !core_reg) // R1
    else $error("Cold reset did not hold the core.");
  a_cold_pll: assert property (state_reg == ST_COLD |-> !pll_reg && !boot_reg.valid) // R2
    else $error("PLL or boot vector not reset in cold reset.");
  a_boot_ext: assert property (state_reg == ST_BOOT && bootSelect && coldSync2 // R3
    |=> boot_reg.fromExt && boot_reg.valid && boot_reg.vec == $past(extVector))
    else $error("External boot vector not loaded.");
  a_boot_nvram: assert property (state_reg == ST_BOOT && !bootSelect && nvValid // R4
    && coldSync2 |=> !boot_reg.fromExt && boot_reg.vec == $past(nvData))
    else $error("Stored boot vector not loaded.");
  a_nv_request: assert property (state_reg == ST_BOOT && !bootSelect && !nvValid // R4
    && coldSync2 |=> nvReq_reg)
    else $error("Storage read not requested.");
  a_run_ready: assert property (state_reg == ST_RUN |-> core_reg && pll_reg // R2
    && boot_reg.valid)
    else $error("Running before boot and lock completed.");
  a_warm_start: assert property (state_reg == ST_RUN && !warmSync2 && coldSync2 // R5
    |=> oe_reg && !core_reg)
    else $error("Warm line assertion ignored.");
  a_warm_drive: assert property (state_reg == ST_WARM |-> oe_reg && !core_reg) // R6
    else $error("Warm line not driven during warm reset.");
  a_warm_hold: assert property ($fell(oe_reg) && state_reg == ST_WREL // R6
    |-> $past(warmCnt_reg) == WARM_CNT_W'(WARM_CYC - 1))
    else $error("Warm line released early.");
  a_bus_toggle: assert property (busCnt_reg == BUS_CNT_W'(BUS_HALF - 1) // R8
    |=> busClk_reg != $past(busClk_reg))
    else $error("Bus clock did not toggle.");
  a_release_sync: assert property ($rose(coldResetN) |-> ##2 !core_reg [*2]) // R9
    else $error("Core left reset without synchronised release.");

  c_ext_boot: cover property (state_reg == ST_BOOT && bootSelect ##1 state_reg == ST_PLL);
  c_nv_boot: cover property (nvReq_reg && nvValid ##1 state_reg == ST_PLL);
  c_warm_done: cover property (state_reg == ST_WREL ##1 state_reg == ST_RUN);
  c_cold_in_warm: cover property (state_reg == ST_WARM ##1 state_reg == ST_COLD);

endmodule : rbv_reset_ctrl

// ===== include/rbv_pkg.sv
// Purpose: Shared constants and types for the reset and boot vector sequencer.
// Assumes: Master clock of 10 MHz (100 ns period).
// Notes:   The warm hold count is derived here from a time in nanoseconds; BUS_HALF is set in cycles.
package rbv_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;   // Master clock period.
  localparam int unsigned WARM_HOLD_NS  = 2000;  // Least time the warm line is driven low.
  // Least time rounds up to whole cycles.
  localparam int unsigned WARM_HOLD_CYC = (WARM_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WARM_CNT_W    = 8;     // Width of the warm hold counter.

  // ****************************************************************
  // Boot vector and clock defaults
  // ****************************************************************
  localparam int unsigned BOOT_W      = 32;      // Boot configuration vector width.
  localparam int unsigned CPU_MULT    = 4;       // Processor clock multiple of master clock.
  localparam int unsigned MULT_W      = 4;       // Width of the multiplier select.
  localparam int unsigned BUS_HALF    = 1;       // Master cycles per bus clock half period.
  localparam int unsigned BUS_CNT_W   = 4;       // Width of the bus clock divider.

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_COLD = 3'h0,  // Cold reset held.
    ST_BOOT = 3'h1,  // Loading boot configuration vector.
    ST_PLL  = 3'h2,  // Waiting for PLL lock.
    ST_RUN  = 3'h3,  // Processor running.
    ST_WARM = 3'h4,  // Driving warm reset line.
    ST_WREL = 3'h5   // Waiting for the warm line to return high.
  } rbv_state_e;

  // Loaded boot configuration with its source.
  typedef struct packed {
    logic [BOOT_W-1:0] vec;      // Vector value.
    logic              fromExt;  // Set when taken from the external source.
    logic              valid;    // Set once the vector is loaded.
  } rbv_boot_s;

endpackage : rbv_pkg

// ===== testbench/rbv_board_model.sv
// Purpose: Board side of the sequencer: on-chip storage, PLL and the warm wire.
// Assumes: The warm wire has a pull-up; the bench may pull it low from outside.
// Notes:   Storage data is shown only with its strobe; otherwise it changes every cycle.
`timescale 1ns/1ns
module rbv_board_model
  import rbv_pkg::*;
#(
  parameter logic [BOOT_W-1:0] NV_WORD = 32'h5EED_0C3A  // Word held in on-chip storage.
) (
  // Clock
  input  wire logic              clk,
  // Storage side
  input  wire logic              nvReq,
  output logic                   nvValid,
  output logic [BOOT_W-1:0]      nvData,
  input  wire logic [3:0]        nvWait,
  // PLL side
  input  wire logic              pllResetN,
  output logic                   pllLocked,
  // Warm wire
  input  wire logic              warmLineOe,
  input  wire logic              warmLineOut,
  input  wire logic              extPullLow,
  output logic                   warmLineIn
);
  logic [3:0] nvCnt;    // Cycles the current storage read has waited.
  logic [2:0] lockCnt;  // Cycles since the PLL left reset.

  // Any party pulling low wins over the pull-up.
  assign warmLineIn = !((warmLineOe && !warmLineOut) || extPullLow);

  initial begin
    nvCnt     = 4'h0;
    lockCnt   = 3'h0;
    nvValid   = 1'b0;
    pllLocked = 1'b0;
    nvData    = ~NV_WORD;
  end

  // Storage answers after nvWait cycles; the PLL locks five cycles after reset.
  always @(posedge clk) begin
    if (nvReq && !nvValid && nvCnt >= nvWait) begin
      nvValid <= 1'b1;
      nvData  <= NV_WORD;
      nvCnt   <= 4'h0;
    end else begin
      nvValid <= 1'b0;
      nvData  <= ~nvData;
      nvCnt   <= nvReq ? nvCnt + 4'h1 : 4'h0;
    end
    if (!pllResetN) begin
      lockCnt   <= 3'h0;
      pllLocked <= 1'b0;
    end else if (lockCnt != 3'h4) begin
      lockCnt <= lockCnt + 3'h1;
    end else begin
      pllLocked <= 1'b1;
    end
  end
endmodule : rbv_board_model

// ===== testbench/reset_and_boot_vector_select_tb_top.sv
// Purpose: Self-checking bench for the reset and boot vector sequencer.
// Assumes: The board model supplies storage, PLL lock and the warm wire.
// Notes:   The warm hold is shortened to 8 cycles to keep the run short.
`timescale 1ns/1ns
module reset_and_boot_vector_select_tb_top import rbv_pkg::*;;
  localparam int unsigned       WCYC = 8;             // Shortened warm hold.
  localparam logic [BOOT_W-1:0] NV_W = 32'h5EED_0C3A; // Word in on-chip storage.
  logic clk, rst_n, coldResetN, warmLineIn, warmLineOut, warmLineOe, warmReq;
  logic bootSelect, nvReq, nvValid, pllResetN, pllLocked, busClock, coreResetN;
  logic              extPullLow;  // Outside party pulling the warm wire low.
  logic [3:0]        nvWait;      // Storage answer delay.
  logic [BOOT_W-1:0] extVector, nvData;
  logic [MULT_W-1:0] pllMult;
  rbv_boot_s         bootCfg;
  int                nErrors, checksDone;

  rbv_reset_ctrl #(.WARM_CYC(WCYC)) i_dut (.clk(clk), .rst_n(rst_n), .coldResetN(coldResetN),
    .warmLineIn(warmLineIn), .warmLineOut(warmLineOut), .warmLineOe(warmLineOe),
    .warmReq(warmReq), .bootSelect(bootSelect), .extVector(extVector), .nvReq(nvReq),
    .nvValid(nvValid), .nvData(nvData), .bootCfg(bootCfg), .pllResetN(pllResetN),
    .pllLocked(pllLocked), .pllMult(pllMult), .busClock(busClock), .coreResetN(coreResetN));
  rbv_board_model #(.NV_WORD(NV_W)) i_board (.clk(clk), .nvReq(nvReq), .nvValid(nvValid),
    .nvData(nvData), .nvWait(nvWait), .pllResetN(pllResetN), .pllLocked(pllLocked),
    .warmLineOe(warmLineOe), .warmLineOut(warmLineOut), .extPullLow(extPullLow),
    .warmLineIn(warmLineIn));

  // 10 MHz master clock.
  always #50 clk = ~clk;

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [BOOT_W+1:0] seen,
                       input logic [BOOT_W+1:0] exp);
    checksDone++;
    if (seen !== exp) begin
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
      nErrors++;
    end
  endtask : check

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Waits, bounded, for the core reset to reach a level.
  task automatic wait_core(input logic lvl);
    int i;
    i = 0;
    while (coreResetN !== lvl && i < 200) begin
      @(negedge clk);
      i++;
    end
    if (coreResetN !== lvl) begin
      $display("wrong value core reset wait: expected %b seen %b", lvl, coreResetN);
      nErrors++;
      end_sim();
    end
  endtask : wait_core

  // Runs a cold reset; warmToo asks for warm reset just before and during it.
  task automatic cold_boot(input logic sel, input logic [BOOT_W-1:0] ev, input logic warmToo);
    @(posedge clk);
    warmReq <= warmToo;
    @(posedge clk);
    coldResetN <= 1'b0;
    bootSelect <= sel;
    extVector  <= ev;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("core reset in cold", coreResetN, 1'b0);
    check("pll reset in cold", pllResetN, 1'b0);
    check("warm drive in cold", warmLineOe, 1'b0);
    @(posedge clk);
    warmReq    <= 1'b0;
    coldResetN <= 1'b1;
    wait_core(1'b1);
    check("pll multiple", pllMult, MULT_W'(CPU_MULT));
  endtask : cold_boot

  // Cold reset taking the external vector.
  task automatic test_ext();
    cold_boot(1'b1, 32'hA5C3_1E7F, 1'b0);
    check("external boot", bootCfg, {32'hA5C3_1E7F, 1'b1, 1'b1});
    $display("test external boot done");
  endtask : test_ext

  // Cold reset from storage, prompt or slow, optionally cutting a warm reset short.
  task automatic test_nv(input logic [3:0] w, input logic abortWarm);
    nvWait <= w;
    cold_boot(1'b0, 32'hFFFF_0000, abortWarm);
    check("storage boot", bootCfg, {NV_W, 1'b0, 1'b1});
    check("storage request dropped", nvReq, 1'b0);
    $display("test storage boot done");
  endtask : test_nv

  // The bus clock toggles steadily.
  task automatic test_bus();
    int   t;
    logic prev;
    t = 0;
    @(negedge clk);
    prev = busClock;
    repeat (8) begin
      @(negedge clk);
      if (busClock !== prev) t++;
      prev = busClock;
    end
    check("bus clock toggles", t, 8 / BUS_HALF);
    $display("test bus clock done");
  endtask : test_bus

  // Warm reset from the wire or from the internal request.
  task automatic test_warm(input logic viaWire);
    rbv_boot_s keep;
    int        oeCnt;
    logic      coreBad;
    logic      lineBad;
    keep    = bootCfg;
    oeCnt   = 0;
    coreBad = 1'b0;
    lineBad = 1'b0;
    @(posedge clk);
    if (viaWire) extPullLow <= 1'b1;
    else warmReq <= 1'b1;
    @(posedge clk);
    warmReq <= 1'b0;
    repeat (60) begin
      @(negedge clk);
      if (warmLineOe === 1'b1) oeCnt++;
      if (warmLineOe === 1'b1 && coreResetN !== 1'b0) coreBad = 1'b1;
      if (warmLineOe === 1'b1 && warmLineOut !== 1'b0) lineBad = 1'b1;
      @(posedge clk);
      if (oeCnt == 3) extPullLow <= 1'b0;
    end
    @(posedge clk);
    extPullLow <= 1'b0;
    check("warm hold cycles", oeCnt, WCYC);
    check("core held in warm", coreBad, 1'b0);
    check("warm line pulled low", lineBad, 1'b0);
    wait_core(1'b1);
    check("vector kept", bootCfg, keep);
    $display("test warm reset done");
  endtask : test_warm

  // Main sequence: reset for two cycles, then each scenario.
  initial begin
    clk        = 1'b0;
    rst_n      = 1'b0;
    coldResetN = 1'b0;
    warmReq    = 1'b0;
    bootSelect = 1'b0;
    extVector  = '0;
    extPullLow = 1'b0;
    nvWait     = 4'h0;
    nErrors    = 0;
    checksDone = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    test_ext();
    test_bus();
    test_warm(1'b1);
    test_warm(1'b0);
    test_nv(4'h0, 1'b0);
    test_nv(4'h5, 1'b1);
    end_sim();
  end
endmodule : reset_and_boot_vector_select_tb_top
